/* hw/awe_map.svh */
`ifndef AWE_MAP_SVH
`define AWE_MAP_SVH
// register byte offsets on the serial register port
`define AWE_OFS_LOW_UPPER 8'h0C
`define AWE_OFS_HIGH_LOWER 8'h0D
`define AWE_OFS_HIGH_UPPER 8'h0E
`define AWE_OFS_DRIVE_12 8'h0F
`define AWE_OFS_DRIVE_3 8'h10
// field positions
`define AWE_FLD_FIRST_LSB 0
`define AWE_FLD_SECOND_LSB 4
`define AWE_FLD_THIRD_LSB 0
// reset values
`define AWE_RST_BYTE 8'h00
`define AWE_RST_FIELD 4'h0
// sequencer revision from which the high limit low byte exists;
// the code is arbitrary, replace it with the real revision level
`define AWE_REV_HIGH_LOWER 8'h40
`endif

/* hw/awe_pkg.sv */
package awe_pkg;
  // one register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } awe_req_t;
  // window compare result
  typedef enum logic [1:0] {
    AWE_IN = 2'b00,
    AWE_BELOW = 2'b01,
    AWE_ABOVE = 2'b10
  } awe_zone_t;
endpackage

/* hw/awe_decomp.sv */
`timescale 1ns/10ps
// expands an 8-bit compressed threshold: upper nibble exponent, lower mantissa
module awe_decomp
  import awe_pkg::*;
(
  input wire logic [7:0] comp_i,
  output logic [15:0] value_o
);
  logic [3:0] expo;
  logic [4:0] mant;
  logic [31:0] wide;
  always_comb begin
    expo = comp_i[7:4];
    mant = {1'b1, comp_i[3:0]};
    wide = {27'h000_0000, mant} << expo;
    // zero stays zero; even exponent 15 fits the 16-bit result, so nothing saturates or wraps
    if (comp_i == 8'h00) begin
      value_o = 16'h0000;
    end else if (wide[31:20] != 12'h000) begin
      value_o = 16'hFFFF;
    end else begin
      value_o = wide[19:4];
    end
  end
endmodule

/* hw/awe_regs.sv */
`timescale 1ns/10ps
`include "awe_map.svh"
module awe_regs
  import awe_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire awe_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] seq_rev_i,
  input wire logic compressed_mode_i,
  input wire logic [7:0] low_limit_lower_i,
  input wire logic use_infrared_i,
  input wire logic [15:0] visible_light_result_i,
  input wire logic [15:0] infrared_light_result_i,
  input wire logic result_valid_i,
  output logic window_event_o,
  output logic [1:0] window_zone_o,
  input wire logic [2:0] emitter_pulse_i,
  output logic [3:0] first_emitter_sink_pin_o,
  output logic [3:0] second_emitter_sink_pin_o,
  output logic [3:0] third_emitter_sink_pin_o
);
  logic [7:0] low_upper_q;
  logic [7:0] high_lower_q;
  logic [7:0] high_upper_q;
  logic [3:0] first_emitter_current_q;
  logic [3:0] second_emitter_current_q;
  logic [3:0] third_emitter_current_q;
  logic high_lower_present;
  logic [15:0] low_dec;
  logic [15:0] high_dec;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic [15:0] sample;
  awe_zone_t zone_d;
  awe_zone_t zone_q;
  logic event_q;
  logic [3:0] sink_q [3];
  logic [3:0] cur [3];

  // the lower byte of the high limit only exists on newer sequencers
  assign high_lower_present = (seq_rev_i >= `AWE_REV_HIGH_LOWER);

  // threshold byte writes; host is expected to pause measurements first,
  // a torn 16-bit update is otherwise seen by the compare
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_upper_q <= `AWE_RST_BYTE;
      high_upper_q <= `AWE_RST_BYTE;
    end else if (req_i.wr) begin
      if (req_i.addr == `AWE_OFS_LOW_UPPER) begin
        low_upper_q <= req_i.wdata;
      end
      if (req_i.addr == `AWE_OFS_HIGH_UPPER) begin
        high_upper_q <= req_i.wdata;
      end
    end
  end

  // no documented reset for this byte; cleared anyway for determinism
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      high_lower_q <= `AWE_RST_BYTE;
    end else if (req_i.wr && req_i.addr == `AWE_OFS_HIGH_LOWER && high_lower_present) begin
      high_lower_q <= req_i.wdata;
    end
  end

  // emitter drive fields; reserved bits of the third register are dropped
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      first_emitter_current_q <= `AWE_RST_FIELD;
      second_emitter_current_q <= `AWE_RST_FIELD;
      third_emitter_current_q <= `AWE_RST_FIELD;
    end else if (req_i.wr) begin
      if (req_i.addr == `AWE_OFS_DRIVE_12) begin
        first_emitter_current_q <= req_i.wdata[`AWE_FLD_FIRST_LSB +: 4];
        second_emitter_current_q <= req_i.wdata[`AWE_FLD_SECOND_LSB +: 4];
      end
      if (req_i.addr == `AWE_OFS_DRIVE_3) begin
        third_emitter_current_q <= req_i.wdata[`AWE_FLD_THIRD_LSB +: 4];
      end
    end
  end

  // registered read data; unmapped and absent addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        `AWE_OFS_LOW_UPPER: rdata_o <= low_upper_q;
        `AWE_OFS_HIGH_LOWER: rdata_o <= high_lower_present ? high_lower_q : 8'h00;
        `AWE_OFS_HIGH_UPPER: rdata_o <= high_upper_q;
        `AWE_OFS_DRIVE_12: rdata_o <= {second_emitter_current_q, first_emitter_current_q};
        `AWE_OFS_DRIVE_3: rdata_o <= {4'h0, third_emitter_current_q};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // old sequencers hold one compressed byte per limit
  awe_decomp u_low_dec (
    .comp_i(low_upper_q),
    .value_o(low_dec)
  );
  awe_decomp u_high_dec (
    .comp_i(high_upper_q),
    .value_o(high_dec)
  );

  // limit assembly and window compare
  always_comb begin
    low_limit = compressed_mode_i ? low_dec : {low_upper_q, low_limit_lower_i};
    high_limit = compressed_mode_i ? high_dec : {high_upper_q, high_lower_q};
    sample = use_infrared_i ? infrared_light_result_i : visible_light_result_i;
    if (sample < low_limit) begin
      zone_d = AWE_BELOW;
    end else if (sample > high_limit) begin
      zone_d = AWE_ABOVE;
    end else begin
      zone_d = AWE_IN;
    end
  end

  // one-cycle event per result that falls outside the window
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      zone_q <= AWE_IN;
      event_q <= 1'b0;
    end else begin
      event_q <= result_valid_i && (zone_d != AWE_IN);
      if (result_valid_i) begin
        zone_q <= zone_d;
      end
    end
  end
  assign window_event_o = event_q;
  assign window_zone_o = zone_q;

  // sink drive: field code only while that emitter is pulsed, else zero
  assign cur[0] = first_emitter_current_q;
  assign cur[1] = second_emitter_current_q;
  assign cur[2] = third_emitter_current_q;
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sink
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          sink_q[g] <= 4'h0;
        end else begin
          // code passes through: 0 off, 1 min up to 15 max
          sink_q[g] <= emitter_pulse_i[g] ? cur[g] : 4'h0;
        end
      end
    end
  endgenerate
  assign first_emitter_sink_pin_o = sink_q[0];
  assign second_emitter_sink_pin_o = sink_q[1];
  assign third_emitter_sink_pin_o = sink_q[2];

  // drive is zero one cycle after the pulse input drops
  property p_sink_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !emitter_pulse_i[0] |=> first_emitter_sink_pin_o == 4'h0;
  endproperty
  a_sink_off: assert property (p_sink_off) else $error("sink drawn while not pulsed");

  property p_sink_on;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      emitter_pulse_i[1] |=> second_emitter_sink_pin_o == $past(second_emitter_current_q);
  endproperty
  a_sink_on: assert property (p_sink_on) else $error("sink code mismatch");

  property p_wr_first;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.wr && req_i.addr == `AWE_OFS_DRIVE_12
      |=> first_emitter_current_q == $past(req_i.wdata[3:0]);
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("first field not written");

  property p_wr_second;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.wr && req_i.addr == `AWE_OFS_DRIVE_12
      |=> second_emitter_current_q == $past(req_i.wdata[7:4]);
  endproperty
  a_wr_second: assert property (p_wr_second) else $error("second field not written");

  property p_rsv_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == `AWE_OFS_DRIVE_3
      |=> rdata_o == {4'h0, $past(third_emitter_current_q)};
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  property p_absent;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == `AWE_OFS_HIGH_LOWER && !high_lower_present |=> rdata_o == 8'h00;
  endproperty
  a_absent: assert property (p_absent) else $error("absent register read nonzero");

  // back-to-back write then read must return the fresh byte
  sequence s_low_wr;
    req_i.wr && req_i.addr == `AWE_OFS_LOW_UPPER;
  endsequence
  sequence s_low_rd;
    req_i.rd && req_i.addr == `AWE_OFS_LOW_UPPER;
  endsequence
  property p_low_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_low_wr ##1 s_low_rd |=> rdata_o == $past(req_i.wdata, 2);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low limit readback wrong");

  property p_high_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.wr && req_i.addr == `AWE_OFS_HIGH_UPPER |=> high_upper_q == $past(req_i.wdata);
  endproperty
  a_high_wr: assert property (p_high_wr) else $error("high limit byte not written");

  property p_event;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      result_valid_i && !compressed_mode_i && !use_infrared_i
      && visible_light_result_i > {high_upper_q, high_lower_q} |=> window_event_o;
  endproperty
  a_event: assert property (p_event) else $error("no event above window");

  property p_reset;
    @(posedge ref_clk_i) !rst_n_i |=> high_upper_q == 8'h00 && third_emitter_current_q == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule

/* tb/awe_host.sv */
`timescale 1ns/10ps
// host stand-in: one access pulse per request, an idle cycle between requests except between the write and read of wr_rd
module awe_host
  import awe_pkg::*;
(
  input wire logic ref_clk_i,
  output awe_req_t req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;
  // limits only change while the bench holds results back
  // three-driver variant, so every emitter field may be set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #1 req_o = '0;
  endtask
  // write then read the same address on the next edge, no idle gap
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge ref_clk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(posedge ref_clk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    #1 req_o = '0;
    d = rdata_i;
  endtask
  // read data is registered, taken after the accepting edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    #1 req_o = '0;
    d = rdata_i;
  endtask
endmodule

/* tb/ambient_window_and_emitter_drive_regs_test.sv */
`timescale 1ns/10ps
module ambient_window_and_emitter_drive_regs_test;
  import awe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  awe_req_t req;
  logic [7:0] rdata;
  logic [7:0] rev = 8'h40;
  logic [7:0] low_lo = 8'h00;
  logic [7:0] rb;
  logic comp = 1'b0;
  logic use_ir = 1'b0;
  logic [15:0] vis = '0;
  logic [15:0] ir = '0;
  logic valid = 1'b0;
  logic [2:0] pulse = '0;
  logic ev;
  logic [1:0] zone;
  logic [3:0] s1, s2, s3;
  int err_total = 0;
  int num_checks = 0;
  logic [7:0] ofs [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
  logic [7:0] wv [5] = '{8'h12, 8'h34, 8'h56, 8'h21, 8'hF7};
  logic [7:0] rv [5] = '{8'h12, 8'h34, 8'h56, 8'h21, 8'h07};
  awe_host host (.ref_clk_i(clk), .req_o(req), .rdata_i(rdata));
  awe_regs dut (.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .rdata_o(rdata),
    .seq_rev_i(rev), .compressed_mode_i(comp), .low_limit_lower_i(low_lo),
    .use_infrared_i(use_ir), .visible_light_result_i(vis), .infrared_light_result_i(ir),
    .result_valid_i(valid), .window_event_o(ev), .window_zone_o(zone),
    .emitter_pulse_i(pulse), .first_emitter_sink_pin_o(s1),
    .second_emitter_sink_pin_o(s2), .third_emitter_sink_pin_o(s3));
  // 25 ns clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(16'(d), 16'(exp));
  endtask
  // one result; the unused source sits inside the uncompressed window to show the select
  task automatic meas(input logic [15:0] v, input logic sel, input awe_zone_t z);
    @(posedge clk);
    #1 use_ir = sel;
    vis = sel ? 16'h3000 : v;
    ir = sel ? v : 16'h3000;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    chk(16'(ev), 16'(z != AWE_IN));
    chk(16'(zone), 16'(z));
  endtask
  task automatic drive(input logic [2:0] p, input logic [11:0] exp);
    @(posedge clk);
    #1 pulse = p;
    @(posedge clk);
    #1 chk(16'({s3, s2, s1}), 16'(exp));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bounded run length
  initial begin
    #200us err_total++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 5; i++) rchk(ofs[i], 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) host.wr(ofs[i], wv[i]);
    for (int i = 0; i < 5; i++) rchk(ofs[i], rv[i]);
    rchk(8'h11, 8'h00);
    $display("test access done");
    drive(3'b111, 12'h721);
    drive(3'b001, 12'h001);
    drive(3'b000, 12'h000);
    host.wr(8'h0F, 8'hF0);
    drive(3'b011, 12'h0F0);
    drive(3'b000, 12'h000);
    $display("test emitters done");
    meas(16'h1000, 1'b0, AWE_BELOW);
    meas(16'h6000, 1'b0, AWE_ABOVE);
    meas(16'h11FF, 1'b1, AWE_BELOW);
    meas(16'h1200, 1'b1, AWE_IN);
    meas(16'h5635, 1'b1, AWE_ABOVE);
    low_lo = 8'h80;
    meas(16'h127F, 1'b0, AWE_BELOW);
    meas(16'h1280, 1'b0, AWE_IN);
    low_lo = 8'h00;
    $display("test window done");
    comp = 1'b1;
    meas(16'h0040, 1'b0, AWE_ABOVE);
    meas(16'h0001, 1'b0, AWE_BELOW);
    meas(16'h0010, 1'b0, AWE_IN);
    comp = 1'b0;
    $display("test compressed done");
    rev = 8'h3F;
    host.wr(8'h0D, 8'h77);
    rchk(8'h0D, 8'h00);
    rev = 8'h40;
    rchk(8'h0D, 8'h34);
    $display("test revision done");
    host.wr_rd(8'h0C, 8'h5A, rb);
    chk(16'(rb), 16'h005A);
    $display("test back-to-back done");
    wrap_up();
  end
endmodule
